// [hw/device_config_word_decode.v]
// Configuration word decoder: capture, static decoded outputs and AHB-Lite read-back
// Operation
// - Bits 2:0 choose PLL input divide ratio
// - Bit 31 gives bus-power pin to USB
// - Bit 30 gives ID pin to USB
// - Bit 26 picks default or alternate CAN pins
// - Bit 25 picks default or alternate Ethernet pins
// - Bit 24 selects MII, else RMII
// - Bits 18:16 assign shadow set to priority
// - User identifier readable on both debug ports
`timescale 1ns/1ps
`include "device_config_regs.vh"
module device_config_word_decode (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [2:0]  hburst,
   input  wire [3:0]  hprot,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg         hreadyout,
   output reg  [31:0] hrdata,
   output reg         hresp,
   input  wire [31:0] nv_word_2,
   input  wire [31:0] nv_word_3,
   input  wire        prog_sclk,
   input  wire        prog_sel,
   output wire        prog_sdo,
   input  wire        jtag_sclk,
   input  wire        jtag_sel,
   output wire        jtag_sdo,
   output reg         config_loaded,
   output reg  [2:0]  pll_input_divider_select,
   output reg  [3:0]  pll_input_divide_ratio,
   output reg         usb_bus_power_pin_owner,
   output reg         usb_id_pin_owner,
   output reg         can_pin_set_select,
   output reg         ethernet_pin_set_select,
   output reg         phy_interface_full_select,
   output reg  [2:0]  shadow_set_priority_select,
   output reg  [7:0]  shadow_set_priority_mask,
   output reg  [15:0] user_identifier
);

   // Divide code to ratio; codes 6 and 7 skip to 10 and 12
   function [3:0] pll_ratio;
      input [2:0] code;
      begin
         case (code)
            3'h0:    pll_ratio = 4'h1;
            3'h1:    pll_ratio = 4'h2;
            3'h2:    pll_ratio = 4'h3;
            3'h3:    pll_ratio = 4'h4;
            3'h4:    pll_ratio = 4'h5;
            3'h5:    pll_ratio = 4'h6;
            3'h6:    pll_ratio = 4'ha;
            3'h7:    pll_ratio = 4'hc;
            default: pll_ratio = 4'h1;
         endcase
      end
   endfunction

   // Register index from a byte address; used for both reads and writes
   function [2:0] reg_select;
      input [`ADDR_DEC_BITS-1:0] addr;
      begin
         case (addr)
            `WORD2_OFS:   reg_select = 3'h1;
            `WORD3_OFS:   reg_select = 3'h2;
            `STATUS_OFS:  reg_select = 3'h3;
            `DECODED_OFS: reg_select = 3'h4;
            default:      reg_select = 3'h0;
         endcase
      end
   endfunction

   wire [31:0] word_2_raw;
   wire [31:0] word_3_raw;
   wire        loaded_raw;
   wire [31:0] word_3_view;
   wire [2:0]  shadow_code;
   wire [7:0]  shadow_mask_d;
   wire        access_take;
   wire [2:0]  access_reg;
   wire        upper_addr_zero;
   wire [31:0] status_word;
   wire [31:0] decoded_word;
   reg  [31:0] rdata_d;
   reg         write_seen_q;
   reg         unmapped_seen_q;
   reg         write_seen_d;
   reg         unmapped_seen_d;

   config_capture u_capture (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .nv_word_2 (nv_word_2),
      .nv_word_3 (nv_word_3),
      .word_2_q  (word_2_raw),
      .word_3_q  (word_3_raw),
      .loaded_q  (loaded_raw)
   );

   // Same identifier feeds both ports; each port keeps its own shifter
   user_id_serial_reader u_prog_reader (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .sclk_pin (prog_sclk),
      .sel_pin  (prog_sel),
      .id_value (user_identifier),
      .sdo_q    (prog_sdo)
   );

   user_id_serial_reader u_jtag_reader (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .sclk_pin (jtag_sclk),
      .sel_pin  (jtag_sel),
      .id_value (user_identifier),
      .sdo_q    (jtag_sdo)
   );

   // Reserved positions forced high so stale storage never shows through
   assign word_3_view = word_3_raw | `WORD3_RSVD_MASK;

   assign shadow_code = word_3_raw[`SHADOW_SEL_MSB:`SHADOW_SEL_LSB];

   // Bit p set means priority p uses the shadow set; code 0 sets all of 1 to 7
   genvar p;
   generate
      for (p = 0; p < 8; p = p + 1) begin : g_shadow
         if (p == 0) begin : g_zero
            assign shadow_mask_d[p] = 1'b0;
         end else begin : g_level
            localparam [2:0] level = p;
            assign shadow_mask_d[p] = (shadow_code == 3'h0) | (shadow_code == level);
         end
      end
   endgenerate

   // Decoded outputs follow the captured words, which never change after load
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         config_loaded              <= 1'b0;
         pll_input_divider_select   <= 3'h0;
         pll_input_divide_ratio     <= 4'h1;
         usb_bus_power_pin_owner    <= 1'b0;
         usb_id_pin_owner           <= 1'b0;
         can_pin_set_select         <= 1'b1;
         ethernet_pin_set_select    <= 1'b1;
         phy_interface_full_select  <= 1'b1;
         shadow_set_priority_select <= 3'h0;
         shadow_set_priority_mask   <= 8'h00;
         user_identifier            <= `ID_RESET;
      end else begin
         config_loaded <= loaded_raw;
         if (loaded_raw) begin
            pll_input_divider_select   <= word_2_raw[`PLL_DIV_MSB:`PLL_DIV_LSB];
            pll_input_divide_ratio     <= pll_ratio(word_2_raw[`PLL_DIV_MSB:`PLL_DIV_LSB]);
            usb_bus_power_pin_owner    <= word_3_raw[`BUS_POWER_OWN_BIT];
            usb_id_pin_owner           <= word_3_raw[`ID_PIN_OWN_BIT];
            can_pin_set_select         <= word_3_raw[`CAN_PINS_BIT];
            ethernet_pin_set_select    <= word_3_raw[`ETH_PINS_BIT];
            phy_interface_full_select  <= word_3_raw[`PHY_FULL_BIT];
            shadow_set_priority_select <= shadow_code;
            shadow_set_priority_mask   <= shadow_mask_d;
            user_identifier            <= word_3_raw[`USER_ID_MSB:`USER_ID_LSB];
         end
      end
   end

   // Address phase is taken on the same edge that the master sees hready
   assign access_take     = hsel & hready & htrans[1];
   assign upper_addr_zero = (haddr[31:`ADDR_DEC_BITS] == 20'h00000);
   assign access_reg      = upper_addr_zero ? reg_select(haddr[`ADDR_DEC_BITS-1:0]) : 3'h0;

   assign status_word = {29'h00000000,
                         unmapped_seen_q,
                         write_seen_q,
                         config_loaded};

   assign decoded_word = {usb_bus_power_pin_owner,
                          usb_id_pin_owner,
                          3'h0,
                          can_pin_set_select,
                          ethernet_pin_set_select,
                          phy_interface_full_select,
                          shadow_set_priority_mask,
                          5'h00,
                          shadow_set_priority_select,
                          pll_input_divide_ratio,
                          1'b0,
                          pll_input_divider_select};

   // Read data is prepared in the address phase so hrdata comes from a flop
   always @* begin
      rdata_d = 32'h00000000;
      case (access_reg)
         3'h1:    rdata_d = word_2_raw;
         3'h2:    rdata_d = word_3_view;
         3'h3:    rdata_d = status_word;
         3'h4:    rdata_d = decoded_word;
         default: rdata_d = 32'h00000000;
      endcase
   end

   // Sticky flags clear on a status read, but a new event in that cycle wins
   always @* begin
      write_seen_d    = write_seen_q;
      unmapped_seen_d = unmapped_seen_q;
      if (access_take && !hwrite && access_reg == 3'h3) begin
         write_seen_d    = 1'b0;
         unmapped_seen_d = 1'b0;
      end
      if (access_take && hwrite) begin
         write_seen_d = 1'b1;
      end
      if (access_take && access_reg == 3'h0) begin
         unmapped_seen_d = 1'b1;
      end
   end

   // Zero wait states; writes are dropped, the words are read-only
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout       <= 1'b1;
         hresp           <= `HRESP_OKAY;
         hrdata          <= 32'h00000000;
         write_seen_q    <= 1'b0;
         unmapped_seen_q <= 1'b0;
      end else begin
         hreadyout       <= 1'b1;
         hresp           <= `HRESP_OKAY;
         write_seen_q    <= write_seen_d;
         unmapped_seen_q <= unmapped_seen_d;
         if (access_take && !hwrite) begin
            hrdata <= rdata_d;
         end else if (access_take) begin
            hrdata <= 32'h00000000;
         end
      end
   end

endmodule // device_config_word_decode

// [common/device_config_regs.vh]
// Offsets, field positions, reset values and timing counts for the configuration word decoder
`ifndef DEVICE_CONFIG_REGS_VH
`define DEVICE_CONFIG_REGS_VH

`define WORD2_OFS          12'h000
`define WORD3_OFS          12'h004
`define STATUS_OFS         12'h008
`define DECODED_OFS        12'h00c
`define ADDR_DEC_BITS      12

`define PLL_DIV_LSB        0
`define PLL_DIV_MSB        2
`define BUS_POWER_OWN_BIT  31
`define ID_PIN_OWN_BIT     30
`define CAN_PINS_BIT       26
`define ETH_PINS_BIT       25
`define PHY_FULL_BIT       24
`define SHADOW_SEL_LSB     16
`define SHADOW_SEL_MSB     18
`define USER_ID_LSB        0
`define USER_ID_MSB        15
`define WORD3_RSVD_MASK    32'h38f80000

`define STAT_LOADED_BIT    0
`define STAT_WRITE_BIT     1
`define STAT_UNMAPPED_BIT  2

`define WORD_RESET         32'hffffffff
`define ID_RESET           16'hffff
`define SYNC_RESET         64'hffffffffffffffff
`define CAPTURE_WAIT       2'h3
`define HRESP_OKAY         1'h0

`endif

// [hw/config_capture.v]
// Synchroniser and one-time capture of the nonvolatile configuration words
`timescale 1ns/1ps
`include "device_config_regs.vh"
module config_capture (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire [31:0] nv_word_2,
   input  wire [31:0] nv_word_3,
   output reg  [31:0] word_2_q,
   output reg  [31:0] word_3_q,
   output reg         loaded_q
);
   reg  [63:0] meta_q;
   reg  [63:0] sync_q;
   reg  [1:0]  wait_q;

   // Words are sampled only after release, never by the reset itself
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_q   <= `SYNC_RESET;
         sync_q   <= `SYNC_RESET;
         wait_q   <= 2'h0;
         word_2_q <= `WORD_RESET;
         word_3_q <= `WORD_RESET;
         loaded_q <= 1'b0;
      end else begin
         meta_q <= {nv_word_3, nv_word_2};
         sync_q <= meta_q;
         if (!loaded_q) begin
            if (wait_q == `CAPTURE_WAIT) begin
               word_2_q <= sync_q[31:0];
               word_3_q <= sync_q[63:32];
               loaded_q <= 1'b1;
            end else begin
               wait_q <= wait_q + 2'h1;
            end
         end
      end
   end
endmodule // config_capture

// [hw/user_id_serial_reader.v]
// Serial read-out of the user identifier for one external debug or programming port
`timescale 1ns/1ps
`include "device_config_regs.vh"
module user_id_serial_reader (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        sclk_pin,
   input  wire        sel_pin,
   input  wire [15:0] id_value,
   output reg         sdo_q
);
   reg  [1:0]  meta_q;
   reg  [1:0]  sync_q;
   reg  [1:0]  prev_q;
   reg  [15:0] shift_q;
   wire        sel_rise;
   wire        sclk_rise;

   // Bit 0 is the serial clock, bit 1 the select
   assign sel_rise  = sync_q[1] & ~prev_q[1];
   assign sclk_rise = sync_q[0] & ~prev_q[0];

   // Port clock must stay well under a quarter of hclk
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_q  <= 2'h0;
         sync_q  <= 2'h0;
         prev_q  <= 2'h0;
         shift_q <= `ID_RESET;
         sdo_q   <= 1'b0;
      end else begin
         meta_q <= {sel_pin, sclk_pin};
         sync_q <= meta_q;
         prev_q <= sync_q;
         if (!sync_q[1]) begin
            sdo_q <= 1'b0;
         end else if (sel_rise) begin
            shift_q <= id_value;
            sdo_q   <= id_value[15];
         end else if (sclk_rise) begin
            shift_q <= {shift_q[14:0], 1'b0};
            sdo_q   <= shift_q[14];
         end
      end
   end
endmodule // user_id_serial_reader

// [test/device_config_word_decode_props.sv]
// Port checker for the configuration word decoder
`timescale 1ns/1ps
`include "device_config_regs.vh"
module device_config_word_decode_props (
   input wire        hclk,
   input wire        hresetn,
   input wire        hsel,
   input wire [31:0] haddr,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire        hready,
   input wire        hreadyout,
   input wire [31:0] hrdata,
   input wire        hresp,
   input wire        prog_sel,
   input wire        prog_sdo,
   input wire        jtag_sel,
   input wire        jtag_sdo,
   input wire        config_loaded,
   input wire [2:0]  pll_input_divider_select,
   input wire [3:0]  pll_input_divide_ratio,
   input wire [2:0]  shadow_set_priority_select,
   input wire [7:0]  shadow_set_priority_mask,
   input wire [15:0] user_identifier
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire [2:0] dv = pll_input_divider_select;
   wire [2:0] sh = shadow_set_priority_select;
   sequence rd_taken;
      hsel && hready && htrans[1] && !hwrite;
   endsequence
   sequence rd_word3;
      rd_taken ##0 (haddr == {20'h0, `WORD3_OFS});
   endsequence
   a_bus_always_okay: assert property (hreadyout && !hresp)
      else $error("bus not ready or not okay");
   a_ratio_from_code: assert property (config_loaded |-> pll_input_divide_ratio ==
      (dv < 3'h6 ? {1'b0, dv} + 4'h1 : (dv == 3'h6 ? 4'ha : 4'hc))) else $error("bad divide ratio");
   a_mask_from_code: assert property (config_loaded |->
      shadow_set_priority_mask == (sh == 3'h0 ? 8'hfe : 8'h01 << sh)) else $error("bad shadow mask");
   a_outputs_stay_static: assert property (config_loaded |=> config_loaded &&
      $stable({dv, sh, pll_input_divide_ratio, user_identifier})) else $error("decoded output moved");
   a_load_after_reset: assert property ($rose(hresetn) |-> ##[1:8] config_loaded)
      else $error("words not loaded in time");
   a_reserved_read_one: assert property (rd_word3 |=>
      (hrdata & `WORD3_RSVD_MASK) == `WORD3_RSVD_MASK) else $error("reserved bits not one");
   a_user_id_read: assert property (rd_word3 |=> hrdata[15:0] == user_identifier)
      else $error("identifier read mismatch");
   a_unmapped_read_zero: assert property (rd_taken ##0
      (haddr[31:12] != 20'h0 || haddr[11:0] > `DECODED_OFS) |=> hrdata == 32'h0) else $error("unmapped not zero");
   a_prog_idle_low: assert property (!prog_sel [*5] |-> !prog_sdo)
      else $error("prog output not low");
   a_jtag_idle_low: assert property (!jtag_sel [*5] |-> !jtag_sdo)
      else $error("jtag output not low");
endmodule // device_config_word_decode_props
bind device_config_word_decode device_config_word_decode_props device_config_word_decode_props_inst (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .prog_sel(prog_sel),
   .prog_sdo(prog_sdo), .jtag_sel(jtag_sel), .jtag_sdo(jtag_sdo), .config_loaded(config_loaded),
   .pll_input_divider_select(pll_input_divider_select), .pll_input_divide_ratio(pll_input_divide_ratio),
   .shadow_set_priority_select(shadow_set_priority_select),
   .shadow_set_priority_mask(shadow_set_priority_mask), .user_identifier(user_identifier));

// [test/device_config_word_decode_tb.sv]
// Register bus and serial port bench for the configuration word decoder
`timescale 1ns/1ps
`include "device_config_regs.vh"
module device_config_word_decode_tb;
   reg         hclk = 1'b0;
   reg         hresetn = 1'b0;
   reg         hsel = 1'b0;
   reg  [31:0] haddr = 32'h0;
   reg  [1:0]  htrans = 2'h0;
   reg         hwrite = 1'b0;
   reg  [31:0] hwdata = 32'h0;
   reg  [31:0] nv2 = 32'h0;
   reg  [31:0] nv3 = 32'h0;
   reg  [1:0]  sclk = 2'h0;
   reg  [1:0]  sel = 2'h0;
   wire        hreadyout;
   wire        hresp;
   wire        loaded;
   wire [31:0] hrdata;
   wire [1:0]  sdo;
   wire [2:0]  div;
   wire [2:0]  shs;
   wire [3:0]  ratio;
   wire [7:0]  mask;
   wire [15:0] uid;
   wire [4:0]  flags;
   int         n_mismatch = 0;
   int         samples_checked = 0;
   always #4 hclk = ~hclk;
   device_config_word_decode device_config_word_decode_inst (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hburst(3'h0), .hprot(4'h3), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .nv_word_2(nv2), .nv_word_3(nv3),
      .prog_sclk(sclk[0]), .prog_sel(sel[0]), .prog_sdo(sdo[0]), .jtag_sclk(sclk[1]), .jtag_sel(sel[1]),
      .jtag_sdo(sdo[1]), .config_loaded(loaded), .pll_input_divider_select(div),
      .pll_input_divide_ratio(ratio), .usb_bus_power_pin_owner(flags[4]), .usb_id_pin_owner(flags[3]),
      .can_pin_set_select(flags[2]), .ethernet_pin_set_select(flags[1]),
      .phy_interface_full_select(flags[0]), .shadow_set_priority_select(shs),
      .shadow_set_priority_mask(mask), .user_identifier(uid));
   task finish_test;
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task chk(input string nm, input [31:0] seen, input [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task bound(input int k);
      if (k >= 64) begin
         n_mismatch++;
         finish_test;
      end
   endtask
   // Master waits on hready each phase; no latency is assumed
   task xfer(input [31:0] a, input w, output [31:0] d);
      int k;
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      k = 0;
      do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 64);
      bound(k);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= ~a;
      k = 0;
      do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 64);
      bound(k);
      d = hrdata;
   endtask
   task rst;
      int k;
      hresetn <= 1'b0;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      k = 0;
      do begin @(posedge hclk); k++; end while (loaded !== 1'b1 && k < 64);
      bound(k);
   endtask
   // Phases of 8 cycles leave margin over the two-flop synchronisers; sdo is read at the edge, long settled
   task ser(input int j, output [15:0] v);
      sel[j] <= 1'b1;
      repeat (8) @(posedge hclk);
      v[15] = sdo[j];
      for (int b = 14; b >= 0; b--) begin
         sclk[j] <= 1'b1;
         repeat (8) @(posedge hclk);
         v[b] = sdo[j];
         sclk[j] <= 1'b0;
         repeat (8) @(posedge hclk);
      end
      sel[j] <= 1'b0;
      repeat (8) @(posedge hclk);
      chk("sdo idle", sdo[j], 32'h0);
   endtask
   reg [31:0] w2, w3, d;
   reg [15:0] v;
   reg [7:0]  mk;
   reg [3:0]  rt;
   reg [2:0]  c;
   initial begin
      for (int i = 0; i < 8; i++) begin
         c = i[2:0];
         w2 = 32'h5a5a5a58 | c;
         w3 = {c[0], c[1], 3'h0, c[2], ~c[0], c[1], 5'h00, c, {4{~c[0], c}}};
         if (c[0])
            w3 = w3 | `WORD3_RSVD_MASK;
         nv2 <= w2;
         nv3 <= w3;
         rst;
         // Storage changes and writes after load must not reach the outputs
         nv2 <= ~w2;
         nv3 <= ~w3;
         xfer({20'h0, `WORD3_OFS}, 1'b1, d);
         repeat (4) @(posedge hclk);
         mk = (c == 3'h0) ? 8'hfe : 8'h01 << c;
         rt = (c < 3'h6) ? {1'b0, c} + 4'h1 : ((c == 3'h6) ? 4'ha : 4'hc);
         chk("divide ratio", ratio, rt);
         chk("divider select", div, c);
         chk("pin owners", flags, {w3[31:30], w3[26:24]});
         chk("shadow mask", mask, mk);
         chk("shadow select", shs, c);
         chk("user id", uid, w3[15:0]);
         xfer({20'h0, `WORD2_OFS}, 1'b0, d);
         chk("word 2", d, w2);
         xfer({20'h0, `WORD3_OFS}, 1'b0, d);
         chk("word 3", d, w3 | `WORD3_RSVD_MASK);
         xfer({20'h0, `DECODED_OFS}, 1'b0, d);
         chk("decoded", d, {w3[31:30], 3'h0, w3[26:24], mk, 5'h00, c, rt, 1'b0, c});
         xfer({20'h0, `STATUS_OFS}, 1'b0, d);
         chk("status write", d, 32'h3);
         xfer(32'h00001000, 1'b0, d);
         chk("unmapped", d, 32'h0);
         xfer({20'h0, `STATUS_OFS}, 1'b0, d);
         chk("status unmapped", d, 32'h5);
         if (c == 3'h5) begin
            ser(0, v);
            chk("prog id", v, w3[15:0]);
            ser(1, v);
            chk("jtag id", v, w3[15:0]);
         end
         $display("config code %0d done", c);
      end
      finish_test;
   end
endmodule // device_config_word_decode_tb
